//--- inc/dot_sub_pkg.sv
`include "dot_sub_regs.svh"

package dot_sub_pkg;

    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_INT = 3'b001,
        OP_Q15 = 3'b010,
        OP_CROSS = 3'b011,
        OP_Q31 = 3'b100
    } op_kind_e;

    typedef struct packed {
        logic [3:0][63:0] upper;
        logic [3:0][63:0] lower;
        logic [31:0] control;
        logic [1:0] irq_status;
        logic [1:0] irq_enable;
        logic aw_have;
        logic [7:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic done;
        logic reserved_exc;
        logic disabled_exc;
    } state_s;

endpackage

//--- inc/dot_sub_regs.svh
`ifndef DOT_SUB_REGS_SVH
`define DOT_SUB_REGS_SVH

// Instruction fields
`define MAJOR_GROUP_CODE 6'h1F
`define DOT_FUNC_CODE 6'h30
`define SUB_INT_HALVES 5'h01
`define SUB_Q15_SAT 5'h05
`define SUB_Q31_FULL_SAT 5'h0D
`define SUB_CROSS_Q15 5'h19

// Fixed-point limits
`define Q15_MIN 16'h8000
`define Q31_MIN 32'h80000000
`define Q31_MAX 32'h7FFFFFFF
`define Q63_MAX 64'h7FFFFFFFFFFFFFFF
`define Q63_MIN 64'h8000000000000000

// Register byte offsets
`define CTRL_OFS 8'h00
`define IRQ_STATUS_OFS 8'h04
`define IRQ_ENABLE_OFS 8'h08
`define IRQ_CLEAR_OFS 8'h0C
`define ACC_BASE_OFS 8'h10
`define ACC_SPAN 8'h20

// Control register layout
`define FLAG_LSB 16
`define CTRL_MASK 32'h000F0000
`define CTRL_RESET 32'h00000000

// Interrupt status bits
`define IRQ_SAT_BIT 0
`define IRQ_EXC_BIT 1
`define IRQ_RESET 2'h0

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- rtl/dot_sub_unit.sv
// What this block does
// RL1 - integer halves: products summed, subtracted, wrap
// RL2 - integer variant leaves saturation flags alone
// RL3 - no operand-dependent exceptions, only saturate/wrap
// RL4 - decode Q15 subtract, sub-code 00101
// RL5 - Q15 product is signed multiply shifted left
// RL6 - both 0x8000 gives 0x7FFFFFFF product
// RL7 - Q15 products summed, subtracted, no accumulator clamp
// RL8 - two-bit select picks one of four accumulators
// RL9 - saturation sets flag bit 16 plus select
// RL10 - Q15: only product saturation sets flag
// RL11 - decode Q31 word subtract, sub-code 01101
// RL12 - Q31: 65-bit subtract, clamp on overflow
// RL13 - Q31: any saturation sets selected flag
// RL14 - cross variant sub-code 11001, swapped halves
// RL15 - extension exceptions block accumulator and flag updates
// RL16 - software supplies operands in proper formats
// RL17 - write sign-extended halves into upper, bottom
// RL18 - Q31 product shifted, clamped when both minimum
`timescale 1ns/1ps
`default_nettype none

`include "dot_sub_regs.svh"

module dot_sub_unit
    import dot_sub_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic issue_valid,
    input wire logic [31:0] instr,
    input wire logic [63:0] source_one,
    input wire logic [63:0] source_two,
    input wire logic ext_reserved,
    input wire logic ext_disabled,
    output logic op_done,
    output logic reserved_exc,
    output logic disabled_exc,
    output logic irq,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    state_s state_q;
    state_s state_d;

    op_kind_e op_kind;
    logic [1:0] sum_register_select;
    logic [1:0][15:0] mul_a;
    logic [1:0][15:0] mul_b;
    logic [1:0][31:0] int_prod;
    logic [1:0][31:0] q31_prod;
    logic [1:0] half_sat;
    logic [63:0] acc_cur;
    logic [32:0] int_dot;
    logic [63:0] q15_dot;
    logic signed [63:0] word_raw;
    logic word_sat;
    logic [63:0] word_prod;
    logic [64:0] word_diff;
    logic [63:0] result;
    logic result_sat;

    // RL4 RL11 RL14 - sub-code decode
    always_comb begin
        op_kind = OP_NONE;
        if (instr[31:26] == `MAJOR_GROUP_CODE && instr[5:0] == `DOT_FUNC_CODE && instr[15:13] == 3'h0) begin
            case (instr[10:6])
                `SUB_INT_HALVES: begin
                    op_kind = OP_INT;
                end
                `SUB_Q15_SAT: begin
                    op_kind = OP_Q15;
                end
                `SUB_Q31_FULL_SAT: begin
                    op_kind = OP_Q31;
                end
                `SUB_CROSS_Q15: begin
                    op_kind = OP_CROSS;
                end
                default: begin
                    op_kind = OP_NONE;
                end
            endcase
        end
    end

    // RL8 - accumulator select field
    assign sum_register_select = instr[12:11];

    // RL14 - cross pairs swap the second operand halves
    always_comb begin
        mul_a[1] = source_one[31:16];
        mul_a[0] = source_one[15:0];
        if (op_kind == OP_CROSS) begin
            mul_b[1] = source_two[15:0];
            mul_b[0] = source_two[31:16];
        end else begin
            mul_b[1] = source_two[31:16];
            mul_b[0] = source_two[15:0];
        end
    end

    // RL5 RL6 - one saturating multiplier per halfword lane
    genvar lane;
    generate
        for (lane = 0; lane < 2; lane++) begin : g_lane
            q15_mul_sat q15_mul_sat_inst (
                .mul_a(mul_a[lane]),
                .mul_b(mul_b[lane]),
                .int_prod(int_prod[lane]),
                .q31_prod(q31_prod[lane]),
                .sat(half_sat[lane])
            );
        end
    endgenerate

    // Accumulator as seen by the datapath: low words of the pair
    assign acc_cur = {state_q.upper[sum_register_select][31:0], state_q.lower[sum_register_select][31:0]};

    // RL1 - integer dot product in 33 bits
    assign int_dot = {int_prod[1][31], int_prod[1]} + {int_prod[0][31], int_prod[0]};

    // RL7 - Q15 products sign-extended to 64 bits
    assign q15_dot = {{32{q31_prod[1][31]}}, q31_prod[1]} + {{32{q31_prod[0][31]}}, q31_prod[0]};

    // RL18 - Q31 product with its one wrapping case clamped
    assign word_raw = $signed(source_one[31:0]) * $signed(source_two[31:0]);
    assign word_sat = (source_one[31:0] == `Q31_MIN) && (source_two[31:0] == `Q31_MIN);
    assign word_prod = word_sat ? `Q63_MAX : {word_raw[62:0], 1'b0};

    // RL12 - subtract with one guard bit
    assign word_diff = {acc_cur[63], acc_cur} - {word_prod[63], word_prod};

    // RL3 - overflow only wraps or clamps, never traps
    always_comb begin
        result = 64'h0;
        result_sat = 1'b0;
        case (op_kind)
            OP_INT: begin
                // RL1 RL2 - wrap, no flag
                result = acc_cur - {{31{int_dot[32]}}, int_dot};
                result_sat = 1'b0;
            end
            OP_Q15, OP_CROSS: begin
                // RL7 RL10 - only products raise the flag
                result = acc_cur - q15_dot;
                result_sat = |half_sat;
            end
            OP_Q31: begin
                // RL12 RL13 - clamp on top-bit mismatch
                if (word_diff[64] != word_diff[63]) begin
                    result = word_diff[64] ? `Q63_MIN : `Q63_MAX;
                    result_sat = 1'b1;
                end else begin
                    result = word_diff[63:0];
                    result_sat = word_sat;
                end
            end
            default: begin
                result = acc_cur;
                result_sat = 1'b0;
            end
        endcase
    end

    // Byte-lane merge for bus writes
    function automatic logic [31:0] merge_lanes(input logic [31:0] old_v, input logic [31:0] new_v,
                                                input logic [3:0] strb);
        logic [31:0] merged;
        merged = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                merged[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return merged;
    endfunction

    // Word offset inside the accumulator window, or out of range
    function automatic logic acc_hit(input logic [7:0] addr);
        logic [7:0] ofs;
        ofs = addr - `ACC_BASE_OFS;
        return (addr >= `ACC_BASE_OFS) && (ofs < `ACC_SPAN);
    endfunction

    function automatic logic [7:0] acc_ofs(input logic [7:0] addr);
        return addr - `ACC_BASE_OFS;
    endfunction

    // Register read mux
    function automatic logic [32:0] read_word(input state_s s, input logic [7:0] addr);
        logic [32:0] rv;
        logic [7:0] ofs;
        rv = {1'b0, 32'h0};
        ofs = acc_ofs(addr);
        case ({addr[7:2], 2'b00})
            `CTRL_OFS: begin
                rv = {1'b0, s.control & `CTRL_MASK};
            end
            `IRQ_STATUS_OFS: begin
                rv = {1'b0, 30'h0, s.irq_status};
            end
            `IRQ_ENABLE_OFS: begin
                rv = {1'b0, 30'h0, s.irq_enable};
            end
            `IRQ_CLEAR_OFS: begin
                rv = {1'b0, 32'h0};
            end
            default: begin
                if (acc_hit(addr)) begin
                    rv = ofs[2] ? {1'b0, s.lower[ofs[4:3]][31:0]} : {1'b0, s.upper[ofs[4:3]][31:0]};
                end else begin
                    rv = {1'b1, 32'h0};
                end
            end
        endcase
        return rv;
    endfunction

    logic [32:0] rd_word;
    logic [7:0] rd_addr;
    logic [7:0] wr_addr;
    logic [7:0] wr_ofs;
    logic [31:0] wr_val;

    assign rd_addr = 8'(s_axi_araddr);
    assign rd_word = read_word(state_q, rd_addr);
    assign wr_addr = state_q.aw_addr;
    assign wr_ofs = acc_ofs(wr_addr);

    assign s_axi_awready = !state_q.aw_have && !state_q.bvalid;
    assign s_axi_wready = !state_q.w_have && !state_q.bvalid;
    assign s_axi_arready = !state_q.rvalid;

    always_comb begin
        state_d = state_q;
        state_d.done = 1'b0;
        state_d.reserved_exc = 1'b0;
        state_d.disabled_exc = 1'b0;
        wr_val = 32'h0;

        // Address and data may arrive in either order
        if (s_axi_awvalid && s_axi_awready) begin
            state_d.aw_have = 1'b1;
            state_d.aw_addr = 8'(s_axi_awaddr);
        end
        if (s_axi_wvalid && s_axi_wready) begin
            state_d.w_have = 1'b1;
            state_d.w_data = s_axi_wdata;
            state_d.w_strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            state_d.bvalid = 1'b0;
        end

        // Software writes are applied before datapath effects,
        // so a same-cycle instruction wins over the bus
        if (state_q.aw_have && state_q.w_have) begin
            state_d.aw_have = 1'b0;
            state_d.w_have = 1'b0;
            state_d.bvalid = 1'b1;
            state_d.bresp = `RESP_OKAY;
            case ({wr_addr[7:2], 2'b00})
                `CTRL_OFS: begin
                    state_d.control = merge_lanes(state_q.control, state_q.w_data, state_q.w_strb) & `CTRL_MASK;
                end
                `IRQ_STATUS_OFS: begin
                    state_d.bresp = `RESP_OKAY;
                end
                `IRQ_ENABLE_OFS: begin
                    wr_val = merge_lanes({30'h0, state_q.irq_enable}, state_q.w_data, state_q.w_strb);
                    state_d.irq_enable = wr_val[1:0];
                end
                `IRQ_CLEAR_OFS: begin
                    if (state_q.w_strb[0]) begin
                        state_d.irq_status = state_q.irq_status & ~state_q.w_data[1:0];
                    end
                end
                default: begin
                    if (acc_hit(wr_addr)) begin
                        if (wr_ofs[2]) begin
                            wr_val = merge_lanes(state_q.lower[wr_ofs[4:3]][31:0], state_q.w_data,
                                                 state_q.w_strb);
                            state_d.lower[wr_ofs[4:3]] = {{32{wr_val[31]}}, wr_val};
                        end else begin
                            wr_val = merge_lanes(state_q.upper[wr_ofs[4:3]][31:0], state_q.w_data,
                                                 state_q.w_strb);
                            state_d.upper[wr_ofs[4:3]] = {{32{wr_val[31]}}, wr_val};
                        end
                    end else begin
                        state_d.bresp = `RESP_SLVERR;
                    end
                end
            endcase
        end

        // Reads answer one cycle after the address is taken
        if (s_axi_rvalid && s_axi_rready) begin
            state_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            state_d.rvalid = 1'b1;
            state_d.rdata = rd_word[31:0];
            state_d.rresp = rd_word[32] ? `RESP_SLVERR : `RESP_OKAY;
        end

        if (issue_valid && op_kind != OP_NONE) begin
            // RL15 - availability check gates every update
            if (ext_reserved) begin
                state_d.reserved_exc = 1'b1;
                state_d.irq_status[`IRQ_EXC_BIT] = 1'b1;
            end else if (ext_disabled) begin
                state_d.disabled_exc = 1'b1;
                state_d.irq_status[`IRQ_EXC_BIT] = 1'b1;
            end else begin
                state_d.done = 1'b1;
                // RL17 - halves stored sign-extended
                state_d.upper[sum_register_select] = {{32{result[63]}}, result[63:32]};
                state_d.lower[sum_register_select] = {{32{result[31]}}, result[31:0]};
                // RL9 - flag chosen by select, others untouched
                if (result_sat) begin
                    state_d.control[`FLAG_LSB + 32'(sum_register_select)] = 1'b1;
                    state_d.irq_status[`IRQ_SAT_BIT] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= '0;
            state_q.control <= `CTRL_RESET;
            state_q.irq_status <= `IRQ_RESET;
            state_q.irq_enable <= `IRQ_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    assign op_done = state_q.done;
    assign reserved_exc = state_q.reserved_exc;
    assign disabled_exc = state_q.disabled_exc;
    // Level output; stays high until software clears the cause
    assign irq = |(state_q.irq_status & state_q.irq_enable);
    assign s_axi_bvalid = state_q.bvalid;
    assign s_axi_bresp = state_q.bresp;
    assign s_axi_rvalid = state_q.rvalid;
    assign s_axi_rdata = state_q.rdata;
    assign s_axi_rresp = state_q.rresp;

endmodule

`default_nettype wire

//--- rtl/q15_mul_sat.sv
`timescale 1ns/1ps
`default_nettype none

`include "dot_sub_regs.svh"

module q15_mul_sat (
    input wire logic [15:0] mul_a,
    input wire logic [15:0] mul_b,
    output logic [31:0] int_prod,
    output logic [31:0] q31_prod,
    output logic sat
);
    logic signed [31:0] raw;

    assign raw = $signed(mul_a) * $signed(mul_b);
    assign int_prod = raw;
    // The only product whose shift would wrap
    assign sat = (mul_a == `Q15_MIN) && (mul_b == `Q15_MIN);
    assign q31_prod = sat ? `Q31_MAX : {raw[30:0], 1'b0};
endmodule

`default_nettype wire

//--- sim/core_issue_model.sv
`timescale 1ns/1ps
`default_nettype none

`include "dot_sub_regs.svh"

module core_issue_model (
    input wire logic core_clk,
    output logic issue_valid,
    output logic [31:0] instr,
    output logic [63:0] source_one,
    output logic [63:0] source_two,
    output logic ext_reserved,
    output logic ext_disabled
);
    initial begin
        issue_valid = 1'b0;
        instr = 32'h0;
        source_one = 64'h0;
        source_two = 64'h0;
        ext_reserved = 1'b0;
        ext_disabled = 1'b0;
    end

    task automatic issue(input logic [4:0] sub, input logic [1:0] acc, input logic [31:0] a,
            input logic [31:0] b, input logic res, input logic dis);
        @(posedge core_clk);
        issue_valid <= 1'b1;
        instr <= {`MAJOR_GROUP_CODE, 10'h000, 3'h0, acc, sub, `DOT_FUNC_CODE};
        source_one <= 64'($signed(a));
        source_two <= 64'($signed(b));
        ext_reserved <= res;
        ext_disabled <= dis;
        @(posedge core_clk);
        // Operands turn to junk so a late sample cannot pass unnoticed
        issue_valid <= 1'b0;
        instr <= ~instr;
        source_one <= ~source_one;
        source_two <= ~source_two;
        ext_reserved <= 1'b0;
        ext_disabled <= 1'b0;
    endtask
endmodule

`default_nettype wire

//--- sim/dot_product_subtract_unit_test.sv
`timescale 1ns/1ps
`default_nettype none

`include "dot_sub_regs.svh"

module dot_product_subtract_unit_test;
    localparam int ADDR_W = 8;
    logic core_clk, rst, op_done, reserved_exc, disabled_exc, irq;
    logic issue_valid, ext_reserved, ext_disabled;
    logic [31:0] instr;
    logic [63:0] source_one, source_two;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_val;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int err_total, num_checks, done_cnt, res_cnt, dis_cnt;
    logic [4:0] subs [6] = '{`SUB_INT_HALVES, `SUB_Q15_SAT, `SUB_CROSS_Q15, `SUB_Q31_FULL_SAT, `SUB_Q31_FULL_SAT,
        `SUB_Q31_FULL_SAT};
    logic [1:0] accs [6] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h1, 2'h2};
    // Last entry drives the word variant into its positive clamp
    logic [63:0] inits [6] = '{64'h5, 64'h0, 64'h0000000100000000, 64'h8000000000000000, 64'h0,
        64'h7FFFFFFFFFFFFFFF};
    logic [31:0] as [6] = '{32'h80000003, 32'h80004000, 32'h00028000, 32'h40000000, 32'h80000000, 32'h40000000};
    logic [31:0] bs [6] = '{32'h8000FFFE, 32'h80004000, 32'h80000003, 32'h40000000, 32'h80000000, 32'hC0000000};

    dot_sub_unit #(.ADDR_W(ADDR_W)) dot_sub_unit_inst (.*);
    core_issue_model core_issue_model_inst (.core_clk(core_clk), .issue_valid(issue_valid), .instr(instr),
        .source_one(source_one), .source_two(source_two), .ext_reserved(ext_reserved),
        .ext_disabled(ext_disabled));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        done_cnt <= done_cnt + int'(op_done === 1'b1);
        res_cnt <= res_cnt + int'(reserved_exc === 1'b1);
        dis_cnt <= dis_cnt + int'(disabled_exc === 1'b1);
    end

    task automatic summarize();
        $display("checks=%0d errors=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        logic aw, w;
        n = 0;
        aw = 1'b1;
        w = 1'b1;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(s_axi_bvalid && !aw && !w) && n < 50) begin
            @(posedge core_clk);
            n++;
            if (aw && s_axi_awready) begin
                aw = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready) begin
                w = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b0;
        if (n >= 50)
            err_total++;
        chk(64'(s_axi_bresp), 64'(er));
    endtask

    task automatic rd(input logic [7:0] a, input logic [1:0] er);
        int n;
        logic ar;
        n = 0;
        ar = 1'b1;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!(s_axi_rvalid && !ar) && n < 50) begin
            @(posedge core_clk);
            n++;
            if (ar && s_axi_arready) begin
                ar = 1'b0;
                s_axi_arvalid <= 1'b0;
            end
        end
        rd_val = s_axi_rdata;
        s_axi_rready <= 1'b0;
        if (n >= 50)
            err_total++;
        chk(64'(s_axi_rresp), 64'(er));
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        rd(a, `RESP_OKAY);
        chk(64'(rd_val), 64'(exp));
    endtask

    function automatic logic [63:0] q15(input logic [15:0] x, input logic [15:0] y, inout logic s);
        logic signed [31:0] p;
        if (x == `Q15_MIN && y == `Q15_MIN) begin
            s = 1'b1;
            return 64'(`Q31_MAX);
        end
        p = ($signed(x) * $signed(y)) <<< 1;
        return 64'(p);
    endfunction

    function automatic logic [63:0] expect_acc(input logic [4:0] sub, input logic [63:0] acc,
            input logic [31:0] a, input logic [31:0] b, output logic s);
        logic signed [31:0] h, l;
        logic signed [63:0] p;
        logic [64:0] t;
        s = 1'b0;
        case (sub)
            `SUB_INT_HALVES: begin
                h = $signed(a[31:16]) * $signed(b[31:16]);
                l = $signed(a[15:0]) * $signed(b[15:0]);
                return acc - (64'(h) + 64'(l));
            end
            `SUB_Q15_SAT: return acc - q15(a[31:16], b[31:16], s) - q15(a[15:0], b[15:0], s);
            `SUB_CROSS_Q15: return acc - q15(a[31:16], b[15:0], s) - q15(a[15:0], b[31:16], s);
            default: begin
                p = ($signed(a) * $signed(b)) <<< 1;
                if (a == `Q31_MIN && b == `Q31_MIN) begin
                    s = 1'b1;
                    p = `Q63_MAX;
                end
                t = {acc[63], acc} - {p[63], p};
                if (t[64] != t[63]) begin
                    s = 1'b1;
                    return t[64] ? `Q63_MIN : `Q63_MAX;
                end
                return t[63:0];
            end
        endcase
    endfunction

    initial begin
        logic [63:0] e;
        logic [31:0] ctl;
        logic [7:0] ad;
        logic s;
        rst = 1'b1;
        s_axi_awaddr = 8'h0;
        s_axi_araddr = 8'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        ctl = 32'h0;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        rdc(`CTRL_OFS, `CTRL_RESET);
        rdc(`IRQ_STATUS_OFS, 32'h0);
        for (int i = 0; i < 6; i++) begin
            ad = 8'(`ACC_BASE_OFS + 8 * accs[i]);
            wr(ad, inits[i][63:32], `RESP_OKAY);
            wr(ad + 8'h4, inits[i][31:0], `RESP_OKAY);
            core_issue_model_inst.issue(subs[i], accs[i], as[i], bs[i], 1'b0, 1'b0);
            e = expect_acc(subs[i], inits[i], as[i], bs[i], s);
            if (s)
                ctl[`FLAG_LSB + accs[i]] = 1'b1;
            rdc(ad, e[63:32]);
            rdc(ad + 8'h4, e[31:0]);
            rdc(`CTRL_OFS, ctl);
            chk(64'(done_cnt), 64'(i + 1));
        end
        $display("test ops done");
        core_issue_model_inst.issue(`SUB_INT_HALVES, 2'h0, 32'h1, 32'h1, 1'b1, 1'b1);
        core_issue_model_inst.issue(`SUB_INT_HALVES, 2'h0, 32'h1, 32'h1, 1'b0, 1'b1);
        core_issue_model_inst.issue(5'h1B, 2'h0, 32'h1, 32'h1, 1'b0, 1'b0);
        rdc(`ACC_BASE_OFS, 32'h80000000);
        rdc(`ACC_BASE_OFS + 8'h4, 32'h0);
        rdc(`CTRL_OFS, ctl);
        chk(64'(res_cnt * 16 + dis_cnt), 64'h11);
        chk(64'(done_cnt), 64'h6);
        $display("test refusals done");
        rdc(`IRQ_STATUS_OFS, 32'h3);
        chk(64'(irq), 64'h0);
        wr(`IRQ_ENABLE_OFS, 32'h2, `RESP_OKAY);
        chk(64'(irq), 64'h1);
        wr(`IRQ_CLEAR_OFS, 32'h2, `RESP_OKAY);
        chk(64'(irq), 64'h0);
        wr(`IRQ_STATUS_OFS, 32'h0, `RESP_OKAY);
        rdc(`IRQ_STATUS_OFS, 32'h1);
        rdc(`IRQ_CLEAR_OFS, 32'h0);
        rd(8'h40, `RESP_SLVERR);
        wr(8'h40, 32'h1, `RESP_SLVERR);
        $display("test registers done");
        summarize();
    end

    initial begin
        #200000;
        err_total++;
        summarize();
    end
endmodule

bind dot_sub_unit dot_sub_checker #(.ADDR_W(ADDR_W)) dot_sub_checker_inst (.*);

`default_nettype wire

//--- sim/dot_sub_checker.sv
`timescale 1ns/1ps
`default_nettype none

`include "dot_sub_regs.svh"

module dot_sub_checker #(
    parameter int ADDR_W = 8
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic issue_valid,
    input wire logic [31:0] instr,
    input wire logic ext_reserved,
    input wire logic ext_disabled,
    input wire logic op_done,
    input wire logic reserved_exc,
    input wire logic disabled_exc,
    input wire logic irq,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready
);
    logic hit;
    logic ar_go;
    assign hit = issue_valid && instr[31:26] == `MAJOR_GROUP_CODE && instr[5:0] == `DOT_FUNC_CODE
        && instr[15:13] == 3'h0
        && instr[10:6] inside {`SUB_INT_HALVES, `SUB_Q15_SAT, `SUB_Q31_FULL_SAT, `SUB_CROSS_Q15};
    assign ar_go = s_axi_arvalid && s_axi_arready;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    run_ok_a: assert property (hit && !ext_reserved && !ext_disabled |=> op_done && !reserved_exc)
        else $error("accepted op gave no done pulse");
    resv_refuse_a: assert property (hit && ext_reserved |=> reserved_exc && !op_done && !disabled_exc)
        else $error("reserved op not refused");
    dis_refuse_a: assert property (hit && !ext_reserved && ext_disabled |=> disabled_exc && !op_done)
        else $error("disabled op not refused");
    no_match_a: assert property (!hit |=> !op_done && !reserved_exc && !disabled_exc)
        else $error("pulse without a decoded op");
    rst_quiet_a: assert property ($fell(rst) |-> !irq && !op_done && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs busy right after reset");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
    rd_answer_a: assert property (ar_go |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    bad_addr_a: assert property (ar_go && s_axi_araddr >= 8'h30 |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");

    cover property (op_done);
    cover property (reserved_exc);
    cover property (disabled_exc);
    cover property (irq);
endmodule

`default_nettype wire
